// ### hw/mute_pkg.sv
// Shared constants and types of the muting and restart interlock block
package mute_pkg;

    // Clock and slow tick
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DIV_W         = 15;

    // Supervision times in milliseconds
    localparam int unsigned CONC_TIME_MS  = 3000;
    localparam int unsigned TOTAL_TIME_MS = 60000;
    localparam int unsigned MS_W          = 17;

    // Synchroniser bit positions
    localparam int unsigned SYN_W         = 6;
    localparam int unsigned SYN_A_ONE     = 0;
    localparam int unsigned SYN_A_TWO     = 1;
    localparam int unsigned SYN_B_ONE     = 2;
    localparam int unsigned SYN_B_TWO     = 3;
    localparam int unsigned SYN_LEAD      = 4;
    localparam int unsigned SYN_BUTTON    = 5;

    // Beam coding settings
    localparam logic [1:0]  CODE_NONE     = 2'h0;
    localparam logic [1:0]  CODE_ONE      = 2'h1;
    localparam logic [1:0]  CODE_TWO      = 2'h2;

    // Direction settings
    localparam logic [1:0]  DIR_BOTH      = 2'h0;
    localparam logic [1:0]  DIR_A_FIRST   = 2'h1;
    localparam logic [1:0]  DIR_B_FIRST   = 2'h2;

    // Application name store
    localparam int unsigned NAME_LEN      = 22;
    localparam int unsigned CHAR_W        = 8;
    localparam int unsigned IDX_W         = 5;
    localparam logic [IDX_W-1:0] NAME_LAST = 5'h15;

    // Reset values
    localparam logic        RST_RREQ      = 1'b1;
    localparam logic        RST_OSSD      = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FIRST_A,
        ST_FIRST_B,
        ST_MUTE_A,
        ST_MUTE_B,
        ST_WAIT_CLEAR
    } mute_st_t;

endpackage

// ### hw/name_if.sv
// Interface between the interlock top and its application name store
`timescale 1ns/1ps
interface name_if;
    import mute_pkg::*;
    logic              we;
    logic [IDX_W-1:0]  idx;
    logic [CHAR_W-1:0] wdata;
    logic [CHAR_W-1:0] rdata;
    modport store (input we, input idx, input wdata, output rdata);
    modport user  (output we, output idx, output wdata, input rdata);
endinterface

// ### hw/name_store.sv
// Application name memory with registered read data
`timescale 1ns/1ps
module name_store
    import mute_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    name_if.store     bus
);

    typedef struct packed {
        logic [NAME_LEN-1:0][CHAR_W-1:0] mem;
        logic [CHAR_W-1:0]               rd;
    } store_t;

    store_t q;
    store_t d;

    // Out of range index writes nothing and reads zero
    always_comb begin
        d = q;
        if (bus.we && bus.idx <= NAME_LAST) begin
            d.mem[bus.idx] = bus.wdata;
        end
        if (bus.idx <= NAME_LAST) begin
            d.rd = q.mem[bus.idx];
        end else begin
            d.rd = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.rdata = q.rd;

endmodule

// ### hw/mute_interlock.sv
// Muting sequencer, restart interlock and beam code gate of the safety receiver
`timescale 1ns/1ps
module mute_interlock
    import mute_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned CONC_MS  = CONC_TIME_MS,
    parameter int unsigned TOTAL_MS = TOTAL_TIME_MS
)(
    input  wire logic              MCLK_I,
    input  wire logic              RESET_N_I,
    input  wire logic              PAIR_A_SENSOR_ONE_I,
    input  wire logic              PAIR_A_SENSOR_TWO_I,
    input  wire logic              PAIR_B_SENSOR_ONE_I,
    input  wire logic              PAIR_B_SENSOR_TWO_I,
    input  wire logic              DIRECTION_LEAD_SIGNAL_I,
    input  wire logic              RESET_BUTTON_I,
    input  wire logic              FIELD_CLEAR_I,
    input  wire logic [1:0]        RX_BEAM_CODE_I,
    input  wire logic [1:0]        CFG_BEAM_CODE_I,
    input  wire logic [1:0]        CFG_DIRECTION_I,
    input  wire logic              CFG_LEAD_EN_I,
    input  wire logic              CFG_RESTART_INTERLOCK_I,
    input  wire logic              CFG_SENSOR_TEST_I,
    input  wire logic              CFG_CONCURRENCE_I,
    input  wire logic              CFG_TOTAL_TIME_I,
    input  wire logic              CFG_END_BY_FIELD_I,
    input  wire logic              APP_NAME_WE_I,
    input  wire logic [IDX_W-1:0]  APP_NAME_IDX_I,
    input  wire logic [CHAR_W-1:0] APP_NAME_CHAR_I,
    output logic                   OSSD_O,
    output logic                   STATE_GREEN_O,
    output logic                   RESET_REQUIRED_O,
    output logic                   MUTING_O,
    output logic                   SEQ_FAULT_O,
    output logic [CHAR_W-1:0]      APP_NAME_CHAR_O
);

    localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(TICK_CYC - 1);
    localparam logic [MS_W-1:0]  CONC_LIM   = MS_W'(CONC_MS);
    localparam logic [MS_W-1:0]  TOTAL_LIM  = MS_W'(TOTAL_MS);

    typedef struct packed {
        logic [SYN_W-1:0] s1;
        logic [SYN_W-1:0] s2;
        logic             btn_prev;
        mute_st_t         st;
        logic             lead_armed;
        logic             field_seen_off;
        logic [DIV_W-1:0] div;
        logic             tick;
        logic [MS_W-1:0]  conc_ms;
        logic [MS_W-1:0]  mute_ms;
        logic             ossd;
        logic             green;
        logic             rreq;
        logic             muting;
        logic             fault;
    } top_state_t;

    top_state_t q;
    top_state_t d;

    ////////////////////////////////////////////////////////////////////////////
    // Application name store

    name_if nbus ();

    assign nbus.we    = APP_NAME_WE_I;
    assign nbus.idx   = APP_NAME_IDX_I;
    assign nbus.wdata = APP_NAME_CHAR_I;

    name_store u_name (
        .clk_i   (MCLK_I),
        .rst_n_i (RESET_N_I),
        .bus     (nbus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decoded conditions; sensor, lead and button terms taken from the second synchroniser stage

    logic sa1, sa2, sb1, sb2, lead, a_both, b_both, all_four, any_on;
    logic field_ok, allow_a, allow_b, lead_ok, partial, conc_fail;
    logic end_time, end_field, end_mute, trip_seq, trip, press, release_ok;

    assign sa1      = q.s2[SYN_A_ONE];
    assign sa2      = q.s2[SYN_A_TWO];
    assign sb1      = q.s2[SYN_B_ONE];
    assign sb2      = q.s2[SYN_B_TWO];
    assign lead     = q.s2[SYN_LEAD];
    assign a_both   = sa1 && sa2;
    assign b_both   = sb1 && sb2;
    assign all_four = a_both && b_both;
    assign any_on   = sa1 || sa2 || sb1 || sb2;

    // Foreign coded beams count as an interrupted path
    assign field_ok = FIELD_CLEAR_I &&
                      (CFG_BEAM_CODE_I == CODE_NONE || RX_BEAM_CODE_I == CFG_BEAM_CODE_I);

    // Direction lock: either pair may lead unless fixed
    assign allow_a  = (CFG_DIRECTION_I != DIR_B_FIRST);
    assign allow_b  = (CFG_DIRECTION_I != DIR_A_FIRST);
    assign lead_ok  = !CFG_LEAD_EN_I || q.lead_armed;

    // Concurrence: a pair half active too long is a fault
    assign partial   = (sa1 ^ sa2) || (sb1 ^ sb2);
    assign conc_fail = CFG_CONCURRENCE_I && (q.conc_ms >= CONC_LIM);

    // Muting terminations other than the sensor pair clearing
    assign end_time  = CFG_TOTAL_TIME_I && (q.mute_ms >= TOTAL_LIM);
    assign end_field = CFG_END_BY_FIELD_I && q.field_seen_off && field_ok;

    // Button edge, judged only on the settled stage
    assign press      = q.s2[SYN_BUTTON] && !q.btn_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        d          = q;
        end_mute   = 1'b0;
        trip_seq   = 1'b0;
        trip       = 1'b0;
        release_ok = 1'b0;

        // Two-stage synchroniser on all sensor and button pins
        d.s1 = {RESET_BUTTON_I, DIRECTION_LEAD_SIGNAL_I, PAIR_B_SENSOR_TWO_I,
                PAIR_B_SENSOR_ONE_I, PAIR_A_SENSOR_TWO_I, PAIR_A_SENSOR_ONE_I};
        d.s2       = q.s1;
        d.btn_prev = q.s2[SYN_BUTTON];

        // Millisecond tick divider
        d.tick = (q.div == DIV_LAST);
        d.div  = (q.div == DIV_LAST) ? '0 : q.div + DIV_W'(1);

        case (q.st)
            ST_IDLE: begin
                d.mute_ms        = '0;
                d.field_seen_off = 1'b0;
                // Lead must be seen before a pair is complete
                if (!lead) begin
                    d.lead_armed = 1'b0;
                end else if (!a_both && !b_both) begin
                    d.lead_armed = 1'b1;
                end
                if (!partial) begin
                    d.conc_ms = '0;
                end else if (q.tick && q.conc_ms != '1) begin
                    d.conc_ms = q.conc_ms + MS_W'(1);
                end
                if (conc_fail) begin
                    trip_seq = 1'b1;
                end else if (a_both && allow_a) begin
                    if (lead_ok) begin
                        d.st = ST_FIRST_A;
                    end else begin
                        trip_seq = 1'b1;
                    end
                end else if (b_both && allow_b) begin
                    if (lead_ok) begin
                        d.st = ST_FIRST_B;
                    end else begin
                        trip_seq = 1'b1;
                    end
                end
            end
            ST_FIRST_A: begin
                if (all_four) begin
                    d.st = ST_MUTE_A;
                end else if (!a_both) begin
                    trip_seq = 1'b1;
                end
            end
            ST_FIRST_B: begin
                if (all_four) begin
                    d.st = ST_MUTE_B;
                end else if (!b_both) begin
                    trip_seq = 1'b1;
                end
            end
            ST_MUTE_A: begin
                if (!b_both) begin
                    end_mute = 1'b1;
                end
            end
            ST_MUTE_B: begin
                if (!a_both) begin
                    end_mute = 1'b1;
                end
            end
            ST_WAIT_CLEAR: begin
                // All sensors must drop before a new cycle may begin
                if (!any_on) begin
                    d.st      = ST_IDLE;
                    d.fault   = 1'b0;
                    d.conc_ms = '0;
                end
            end
            default: begin
                trip_seq = 1'b1;
            end
        endcase

        // Supervision common to every muting state
        if (q.muting) begin
            if (q.tick && q.mute_ms != '1) begin
                d.mute_ms = q.mute_ms + MS_W'(1);
            end
            if (!field_ok) begin
                d.field_seen_off = 1'b1;
            end
            if (end_time || end_field) begin
                end_mute = 1'b1;
            end
        end

        // A violated sequence parks the machine until sensors clear
        if (trip_seq) begin
            d.st    = ST_WAIT_CLEAR;
            d.fault = 1'b1;
        end else if (end_mute) begin
            // Sensor test and field end both demand a clean restart of the sequence
            d.st = (CFG_SENSOR_TEST_I || CFG_END_BY_FIELD_I) ? ST_WAIT_CLEAR : ST_IDLE;
        end

        d.muting = (d.st == ST_FIRST_A) || (d.st == ST_FIRST_B) ||
                   (d.st == ST_MUTE_A)  || (d.st == ST_MUTE_B);

        // Blocked path without muting, or a sequence fault, trips the outputs
        trip = (!field_ok && !d.muting) || trip_seq;

        // Restart latch: a trip in the same cycle as a press keeps it set
        if (!CFG_RESTART_INTERLOCK_I) begin
            d.rreq = 1'b0;
        end else if (trip) begin
            d.rreq = 1'b1;
        end else if (press && q.rreq && field_ok && !d.fault) begin
            d.rreq     = 1'b0;
            release_ok = 1'b1;
        end

        d.ossd  = !d.rreq && !d.fault && (field_ok || d.muting);
        d.green = !d.rreq && !d.fault && (field_ok || d.muting);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
            q      <= '0;
            q.st   <= ST_IDLE;
            q.rreq <= RST_RREQ;
            q.ossd <= RST_OSSD;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign OSSD_O           = q.ossd;
    assign STATE_GREEN_O    = q.green;
    assign RESET_REQUIRED_O = q.rreq;
    assign MUTING_O         = q.muting;
    assign SEQ_FAULT_O      = q.fault;
    assign APP_NAME_CHAR_O  = nbus.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_sync_delay;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        $past(RESET_N_I, 2) |-> q.s2[SYN_A_ONE] == $past(PAIR_A_SENSOR_ONE_I, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sensor not synchronised in two stages");
    property p_mute_start;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (q.st == ST_IDLE && a_both && allow_a && lead_ok && !conc_fail) |=> (q.muting && q.st == ST_FIRST_A);
    endproperty
    a_mute_start: assert property (p_mute_start) else $error("muting did not start on first pair");
    property p_accept;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (q.st == ST_FIRST_B && all_four && !end_time && !end_field) |=> q.st == ST_MUTE_B;
    endproperty
    a_accept: assert property (p_accept) else $error("all four sensors did not accept muting");
    property p_hold;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (q.st == ST_MUTE_A && b_both && !end_time && !end_field) |=> (q.st == ST_MUTE_A && MUTING_O);
    endproperty
    a_hold: assert property (p_hold) else $error("muting dropped while second pair active");
    property p_end;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (q.st == ST_MUTE_A && !b_both) |=> !q.muting;
    endproperty
    a_end: assert property (p_end) else $error("muting kept after second pair cleared");
    property p_direction;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (q.st == ST_IDLE && CFG_DIRECTION_I == DIR_A_FIRST) |=> q.st != ST_FIRST_B;
    endproperty
    a_direction: assert property (p_direction) else $error("muting began in forbidden direction");
    property p_lead;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (q.st == ST_IDLE && CFG_LEAD_EN_I && !q.lead_armed) |=> !q.muting;
    endproperty
    a_lead: assert property (p_lead) else $error("muting without preceding lead signal");
    property p_blocked_off;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (!field_ok && !d.muting) |=> (!OSSD_O && (RESET_REQUIRED_O || !$past(CFG_RESTART_INTERLOCK_I)));
    endproperty
    a_blocked_off: assert property (p_blocked_off) else $error("outputs on with blocked path");
    property p_latch_holds;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (CFG_RESTART_INTERLOCK_I && q.rreq && !press) |=> (RESET_REQUIRED_O && !OSSD_O);
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("interlock released without button");
    property p_release;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        release_ok |=> (OSSD_O && STATE_GREEN_O && !RESET_REQUIRED_O);
    endproperty
    a_release: assert property (p_release) else $error("reset button did not release outputs");
    property p_no_interlock;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        !CFG_RESTART_INTERLOCK_I |=> !RESET_REQUIRED_O;
    endproperty
    a_no_interlock: assert property (p_no_interlock) else $error("restart gated while interlock disabled");
    property p_code_reject;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        (CFG_BEAM_CODE_I != CODE_NONE && RX_BEAM_CODE_I != CFG_BEAM_CODE_I && !d.muting) |=> !OSSD_O;
    endproperty
    a_code_reject: assert property (p_code_reject) else $error("foreign beam code accepted");
    property p_seq_fault;
        @(posedge MCLK_I) disable iff (!RESET_N_I)
        trip_seq |=> (SEQ_FAULT_O && !OSSD_O && (RESET_REQUIRED_O || !$past(CFG_RESTART_INTERLOCK_I)));
    endproperty
    a_seq_fault: assert property (p_seq_fault) else $error("sequence fault did not trip outputs");

endmodule

// ### verification/machine_ctrl_model.sv
// Behavioural model of the machine controller with its own restart interlock
`timescale 1ns/1ps
module machine_ctrl_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ossd_i,
    input  wire logic restart_btn_i,
    output logic      run_o
);
    logic btn_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Only a fresh restart press made while the device outputs are on starts the
    // machine, so a press made before the device reset is lost for good
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            run_o <= 1'b0;
            btn_q <= 1'b0;
        end else begin
            btn_q <= restart_btn_i;
            if (!ossd_i) begin
                run_o <= 1'b0;
            end else if (restart_btn_i && !btn_q) begin
                run_o <= 1'b1;
            end
        end
    end
endmodule

// ### verification/testbench.sv
// Self-checking testbench of the muting sequencer and restart interlock
`timescale 1ns/1ps
module testbench;
    import mute_pkg::*;
    // Option bit positions inside opt
    localparam int O_LEAD = 5, O_RSI = 4, O_TEST = 3, O_CONC = 2, O_TOTAL = 1, O_FEND = 0;
    // Beam table entries: {configured code, received code, outputs on}
    localparam logic [4:0] BEAM [5] = '{5'h01, 5'h0b, 5'h0c, 5'h15, 5'h12};
    logic              clk        = 1'b0;
    logic              rst_n      = 1'b0;
    logic [3:0]        sen        = 4'h0;  // {A one, A two, B one, B two}
    logic              lead       = 1'b0;
    logic              btn        = 1'b0;
    logic              field      = 1'b1;
    logic              restart    = 1'b0;
    logic [1:0]        rx         = 2'h0;
    logic [1:0]        code       = 2'h0;
    logic [1:0]        dir        = 2'h0;
    logic [5:0]        opt        = 6'h10;
    logic              we         = 1'b0;
    logic [IDX_W-1:0]  idx        = 5'h00;
    logic [CHAR_W-1:0] wch        = 8'h00;
    logic              ossd, green, rreq, muting, fault, run;
    logic [CHAR_W-1:0] rch;
    int                fail_count = 0;
    int                checks     = 0;

    // Free-running system clock
    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Short tick and supervision times keep the run brief
    mute_interlock #(.TICK_CYC(4), .CONC_MS(5), .TOTAL_MS(20)) dut (
        .MCLK_I(clk), .RESET_N_I(rst_n),
        .PAIR_A_SENSOR_ONE_I(sen[3]), .PAIR_A_SENSOR_TWO_I(sen[2]),
        .PAIR_B_SENSOR_ONE_I(sen[1]), .PAIR_B_SENSOR_TWO_I(sen[0]),
        .DIRECTION_LEAD_SIGNAL_I(lead), .RESET_BUTTON_I(btn), .FIELD_CLEAR_I(field),
        .RX_BEAM_CODE_I(rx), .CFG_BEAM_CODE_I(code), .CFG_DIRECTION_I(dir),
        .CFG_LEAD_EN_I(opt[O_LEAD]), .CFG_RESTART_INTERLOCK_I(opt[O_RSI]),
        .CFG_SENSOR_TEST_I(opt[O_TEST]), .CFG_CONCURRENCE_I(opt[O_CONC]),
        .CFG_TOTAL_TIME_I(opt[O_TOTAL]), .CFG_END_BY_FIELD_I(opt[O_FEND]),
        .APP_NAME_WE_I(we), .APP_NAME_IDX_I(idx), .APP_NAME_CHAR_I(wch),
        .OSSD_O(ossd), .STATE_GREEN_O(green), .RESET_REQUIRED_O(rreq),
        .MUTING_O(muting), .SEQ_FAULT_O(fault), .APP_NAME_CHAR_O(rch)
    );
    machine_ctrl_model machine (.clk_i(clk), .rst_n_i(rst_n), .ossd_i(ossd), .restart_btn_i(restart), .run_o(run));

    ////////////////////////////////////////////////////////////////////////////////
    // Inputs always change 2 ns after a rising edge, away from the sampling point
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Compare {fault, outputs on, reset required, muting} as one nibble
    task automatic st(input string name, input logic [3:0] exp);
        chk(name, 8'({fault, ossd, rreq, muting}), 8'(exp));
    endtask
    // Held two cycles so the synchroniser surely sees a rising edge
    task automatic press();
        btn = 1'b1;
        cyc(2);
        btn = 1'b0;
        cyc(3);
    endtask
    task automatic restart_press();
        restart = 1'b1;
        cyc(2);
        restart = 1'b0;
        cyc(1);
    endtask
    // Full passage: first pair, all four, second pair only, all clear
    task automatic mute_pass(input logic [3:0] first, input logic [3:0] second);
        sen = first;
        cyc(4);
        st("mute_first", 4'h5);
        sen = 4'hf;
        cyc(4);
        sen = second;
        cyc(4);
        st("mute_second", 4'h5);
        sen = 4'h0;
        cyc(4);
        st("mute_over", 4'h4);
    endtask
    task automatic nm_wr(input logic [IDX_W-1:0] i, input logic [CHAR_W-1:0] c);
        we = 1'b1;
        idx = i;
        wch = c;
        cyc(1);
        we = 1'b0;
        cyc(1);
    endtask
    task automatic nm_rd(input logic [IDX_W-1:0] i, input logic [CHAR_W-1:0] c);
        idx = i;
        cyc(2);
        chk("app_name", rch, c);
    endtask
    task conclude();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        cyc(8);
        rst_n = 1'b1;
        cyc(1);
        st("after_reset", 4'h2);
        press();
        st("reset_release", 4'h4);
        chk("green", 8'(green), 8'h01);
        // Exact latency through the synchroniser, then an end while blocked
        sen = 4'hc;
        cyc(2);
        st("mute_not_yet", 4'h4);
        cyc(1);
        st("mute_start", 4'h5);
        field = 1'b0;
        cyc(2);
        st("field_bypassed", 4'h5);
        sen = 4'hf;
        cyc(4);
        sen = 4'h3;
        cyc(4);
        st("mute_held", 4'h5);
        sen = 4'h1;
        cyc(4);
        chk("blocked_end_ossd", 8'(ossd), 8'h00);
        chk("blocked_end_rreq", 8'(rreq), 8'h01);
        sen = 4'h0;
        field = 1'b1;
        cyc(4);
        press();
        // First pair lost before all four were seen
        sen = 4'hc;
        cyc(4);
        sen = 4'h8;
        cyc(4);
        st("pair_dropped", 4'ha);
        sen = 4'h0;
        cyc(4);
        st("fault_cleared", 4'h2);
        press();
        mute_pass(4'h3, 4'hc);
        // Each fixed direction refuses the other pair
        for (int i = 0; i < 2; i++) begin
            dir = (i == 0) ? DIR_A_FIRST : DIR_B_FIRST;
            sen = (i == 0) ? 4'h3 : 4'hc;
            cyc(4);
            st("dir_refused", 4'h4);
            sen = 4'h0;
            cyc(4);
        end
        dir = DIR_A_FIRST;
        mute_pass(4'hc, 4'h3);
        dir = DIR_BOTH;
        // Lead signal: missing, then raised ahead of the first pair
        opt[O_LEAD] = 1'b1;
        sen = 4'hc;
        cyc(4);
        st("lead_missing", 4'ha);
        sen = 4'h0;
        cyc(4);
        press();
        lead = 1'b1;
        cyc(3);
        mute_pass(4'hc, 4'h3);
        lead = 1'b0;
        opt[O_LEAD] = 1'b0;
        // Concurrence supervision on a half-active pair
        opt[O_CONC] = 1'b1;
        sen = 4'h8;
        cyc(12);
        st("conc_running", 4'h4);
        cyc(30);
        st("conc_expired", 4'ha);
        sen = 4'h0;
        cyc(4);
        press();
        opt[O_CONC] = 1'b0;
        // Total muting time, then end by the field; both wait for all clear
        opt[O_TOTAL] = 1'b1;
        opt[O_FEND] = 1'b1;
        sen = 4'hc;
        cyc(4);
        sen = 4'hf;
        cyc(50);
        st("total_running", 4'h5);
        cyc(50);
        st("total_expired", 4'h4);
        sen = 4'h0;
        cyc(4);
        opt[O_TOTAL] = 1'b0;
        sen = 4'hc;
        cyc(4);
        sen = 4'hf;
        field = 1'b0;
        cyc(3);
        field = 1'b1;
        cyc(3);
        st("field_end", 4'h4);
        sen = 4'h0;
        cyc(4);
        opt[O_FEND] = 1'b0;
        // Sensor test: a sensor left on after the end must block a fresh start
        opt[O_TEST] = 1'b1;
        sen = 4'hc;
        cyc(4);
        sen = 4'hf;
        cyc(4);
        sen = 4'h2;
        cyc(4);
        sen = 4'he;
        cyc(4);
        st("test_blocks_start", 4'h4);
        sen = 4'h0;
        cyc(4);
        opt[O_TEST] = 1'b0;
        // Interlock latches against presses while blocked
        field = 1'b0;
        cyc(1);
        st("blocked", 4'h2);
        press();
        st("press_blocked", 4'h2);
        field = 1'b1;
        cyc(3);
        st("still_latched", 4'h2);
        press();
        st("released", 4'h4);
        // Machine restart order
        restart_press();
        chk("machine_runs", 8'(run), 8'h01);
        field = 1'b0;
        cyc(1);
        field = 1'b1;
        restart_press();
        press();
        chk("machine_stays", 8'(run), 8'h00);
        restart_press();
        chk("machine_restart", 8'(run), 8'h01);
        // Interlock off: outputs follow the field
        opt[O_RSI] = 1'b0;
        cyc(2);
        chk("rreq_off", 8'(rreq), 8'h00);
        field = 1'b0;
        cyc(1);
        st("free_blocked", 4'h0);
        field = 1'b1;
        cyc(1);
        st("free_clear", 4'h4);
        // Every beam coding with its own code, and a foreign code for both coded settings
        for (int i = 0; i < 5; i++) begin
            code = BEAM[i][4:3];
            rx = BEAM[i][2:1];
            cyc(2);
            chk("beam_code", 8'(ossd), 8'(BEAM[i][0]));
        end
        // Application name store, last index and out-of-range index
        nm_wr(5'h00, 8'h41);
        nm_wr(5'h15, 8'h5a);
        nm_wr(5'h16, 8'h33);
        nm_rd(5'h00, 8'h41);
        nm_rd(5'h15, 8'h5a);
        nm_rd(5'h01, 8'h00);
        nm_rd(5'h16, 8'h00);
        conclude();
    end

    // Watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule
